// ===== core/pot_register_map.v
/*
 Register bank and command checker of a single-channel digital potentiometer.
 Holds the wiper register, the terminal control register, the error flag,
 the active wiper behind the write latch and the terminal outputs.
 Assumes an upstream serial engine that decodes address, command and data,
 presents them as a one-cycle strobe, and flags Start and command completion.
 Assumes all inputs are synchronous to CLK and that RST stands for the
 power-on or brown-out event of the digital supply.
 Assumes the serial engine does not forward anything while the error is set;
 commands that still arrive then are dropped here as well.
 The analog ladder and the switches sit outside; they see only the
 registered wiper code and the connect levels.
*/
`timescale 1ns/1ps
`include "pot_regs_defs.vh"

module pot_register_map #(
    parameter WIPER_BITS = 8
) (
    input wire CLK,
    input wire RST,
    input wire CE,
    input wire SDA_IN,
    input wire SCL_IN,
    input wire START_SEEN,
    input wire CMD_VALID,
    input wire [3:0] CMD_ADDR,
    input wire [1:0] CMD_OP,
    input wire [7:0] CMD_DATA,
    input wire CMD_DONE,
    input wire WRITE_LATCH_N,
    input wire HW_SHUTDOWN_N,
    output reg [7:0] RD_DATA,
    output reg RD_VALID,
    output reg CMD_ERROR,
    output reg BUS_ACTIVE,
    output reg [7:0] WIPER_ACTIVE,
    output reg TERM_A_CONNECT,
    output reg TERM_W_CONNECT,
    output reg TERM_B_CONNECT,
    output reg SHUTDOWN_CFG
);

    localparam [7:0] MID_CODE = (WIPER_BITS == 8) ? `WIPER_MID_8BIT : `WIPER_MID_7BIT;
    localparam [7:0] FULL_CODE = (WIPER_BITS == 8) ? 8'hFF : 8'h7F;

    // Stored registers and their next values
    reg [7:0] wiper_position_ff;
    reg [3:0] terminal_connect_control_ff;
    reg [3:0] pending_terminal_connect_reg_ff;
    reg pending_valid_ff;
    reg [7:0] nxt_wiper_position;
    reg [3:0] nxt_terminal_connect_control;
    reg [3:0] nxt_pending_terminal_connect_reg;
    reg nxt_pending_valid;
    // Previous line levels for the activity detect
    reg sda_prev_ff;
    reg scl_prev_ff;

    // Address and command decode
    wire addr_wiper = (CMD_ADDR == `ADDR_WIPER);
    wire addr_terminal_connect_reg = (CMD_ADDR == `ADDR_TERMINAL_CONNECT_REG);
    wire op_step = (CMD_OP == `CMD_INC) || (CMD_OP == `CMD_DEC);
    // Legal command check per address
    wire cmd_ok = addr_wiper || (addr_terminal_connect_reg && !op_step);
    wire cmd_bad = CMD_VALID && !cmd_ok;
    // Nothing is taken while the error stands, reads included
    wire accept = CMD_VALID && cmd_ok && !CMD_ERROR;
    // Stored terminal bits and the combined shutdown request
    wire [3:0] terminal_connect_reg_bits = terminal_connect_control_ff;
    wire soft_shutdown_n = terminal_connect_reg_bits[`TERMINAL_CONNECT_REG_SOFT_HW_SHUTDOWN_N_BIT];
    wire shut = !HW_SHUTDOWN_N || !soft_shutdown_n;

    // Wiper next value; steps stop at the end codes instead of wrapping
    always @* begin
        nxt_wiper_position = wiper_position_ff;
        if (accept && addr_wiper) begin
            case (CMD_OP)
                `CMD_WRITE: begin
                    nxt_wiper_position = CMD_DATA & FULL_CODE;
                end
                `CMD_INC: begin
                    if (wiper_position_ff != FULL_CODE) begin
                        nxt_wiper_position = wiper_position_ff + 8'h01;
                    end
                end
                `CMD_DEC: begin
                    if (wiper_position_ff != 8'h00) begin
                        nxt_wiper_position = wiper_position_ff - 8'h01;
                    end
                end
                default: begin
                    nxt_wiper_position = wiper_position_ff;
                end
            endcase
        end
    end

    // Terminal write is held until the command ends, so terminals never see a partial frame
    always @* begin
        nxt_pending_terminal_connect_reg = pending_terminal_connect_reg_ff;
        nxt_pending_valid = pending_valid_ff;
        nxt_terminal_connect_control = terminal_connect_control_ff;
        if (accept && addr_terminal_connect_reg && CMD_OP == `CMD_WRITE) begin
            nxt_pending_terminal_connect_reg = CMD_DATA[3:0];
            nxt_pending_valid = 1'b1;
        end else if (CMD_DONE && pending_valid_ff) begin
            nxt_terminal_connect_control = pending_terminal_connect_reg_ff;
            nxt_pending_valid = 1'b0;
        end
        // A Start abandons any write not yet completed, unless a terminal command is accepted in the same cycle
        if (START_SEEN && !(accept && addr_terminal_connect_reg)) begin
            nxt_pending_valid = 1'b0;
        end
    end

    // Register storage; reset restores the volatile defaults
    always @(posedge CLK) begin
        if (RST) begin
            wiper_position_ff <= MID_CODE;
            terminal_connect_control_ff <= 4'hF;
            pending_terminal_connect_reg_ff <= 4'hF;
            pending_valid_ff <= 1'b0;
        end else if (CE) begin
            wiper_position_ff <= nxt_wiper_position;
            terminal_connect_control_ff <= nxt_terminal_connect_control;
            pending_terminal_connect_reg_ff <= nxt_pending_terminal_connect_reg;
            pending_valid_ff <= nxt_pending_valid;
        end
    end

    // Error flag: a bad command in the Start cycle still wins
    always @(posedge CLK) begin
        if (RST) begin
            CMD_ERROR <= 1'b0;
        end else if (CE) begin
            if (cmd_bad) begin
                CMD_ERROR <= 1'b1;
            end else if (START_SEEN) begin
                CMD_ERROR <= 1'b0;
            end
        end
    end

    // Read answers; upper terminal bits always read as one
    always @(posedge CLK) begin
        if (RST) begin
            RD_DATA <= 8'h00;
            RD_VALID <= 1'b0;
        end else if (CE) begin
            RD_VALID <= accept && (CMD_OP == `CMD_READ);
            if (accept && CMD_OP == `CMD_READ) begin
                if (addr_wiper) begin
                    RD_DATA <= wiper_position_ff;
                end else begin
                    RD_DATA <= `TERMINAL_CONNECT_REG_FIXED_ONES | {4'h0, terminal_connect_reg_bits};
                end
            end
        end
    end

    // Activity detect: idle when both lines hold still
    // Reset copies the present levels so no false change follows reset
    always @(posedge CLK) begin
        if (RST) begin
            sda_prev_ff <= SDA_IN;
            scl_prev_ff <= SCL_IN;
            BUS_ACTIVE <= 1'b0;
        end else if (CE) begin
            sda_prev_ff <= SDA_IN;
            scl_prev_ff <= SCL_IN;
            BUS_ACTIVE <= (SDA_IN != sda_prev_ff) || (SCL_IN != scl_prev_ff);
        end
    end

    // Wiper transfer gated by write latch; terminal outputs with shutdown override
    always @(posedge CLK) begin
        if (RST) begin
            WIPER_ACTIVE <= MID_CODE;
            TERM_A_CONNECT <= 1'b1;
            TERM_W_CONNECT <= 1'b1;
            TERM_B_CONNECT <= 1'b1;
            SHUTDOWN_CFG <= 1'b0;
        end else if (CE) begin
            // Latch high freezes the wiper while the register keeps taking writes
            if (!WRITE_LATCH_N) begin
                WIPER_ACTIVE <= wiper_position_ff;
            end
            SHUTDOWN_CFG <= shut;
            // Shutdown opens A and ties W to B, stored bits untouched
            TERM_A_CONNECT <= shut ? 1'b0 : terminal_connect_reg_bits[`TERMINAL_CONNECT_REG_TERM_A_BIT];
            TERM_W_CONNECT <= shut ? 1'b1 : terminal_connect_reg_bits[`TERMINAL_CONNECT_REG_TERM_W_BIT];
            TERM_B_CONNECT <= shut ? 1'b1 : terminal_connect_reg_bits[`TERMINAL_CONNECT_REG_TERM_B_BIT];
        end
    end

endmodule // pot_register_map

// ===== core/pot_regs_defs.vh
/*
 Register map constants for the digital potentiometer register bank.
 Assumes inclusion by the bank module only; definitions, no logic.
*/
`ifndef POT_REGS_DEFS_VH
`define POT_REGS_DEFS_VH

// Register addresses within the 16-location space
`define ADDR_WIPER 4'h0
`define ADDR_TERMINAL_CONNECT_REG 4'h4

// Command codes carried with each serial command
`define CMD_WRITE 2'h0
`define CMD_INC 2'h1
`define CMD_DEC 2'h2
`define CMD_READ 2'h3

// Reset values and fixed read-as-one bits
`define WIPER_MID_8BIT 8'h7F
`define WIPER_MID_7BIT 8'h3F
`define TERMINAL_CONNECT_REG_RESET 8'hFF
`define TERMINAL_CONNECT_REG_FIXED_ONES 8'hF0

// Terminal control field positions
`define TERMINAL_CONNECT_REG_SOFT_HW_SHUTDOWN_N_BIT 3
`define TERMINAL_CONNECT_REG_TERM_A_BIT 2
`define TERMINAL_CONNECT_REG_TERM_W_BIT 1
`define TERMINAL_CONNECT_REG_TERM_B_BIT 0

`endif

// ===== tb/pot_register_map_properties.sv
/* Port assertions for the potentiometer register bank.
 Assumes binding onto pot_register_map with CE held high. */
`timescale 1ns/1ps
module pot_register_map_properties (input wire CLK, RST, CE, SDA_IN, SCL_IN, START_SEEN, CMD_VALID, CMD_DONE,
    WRITE_LATCH_N, HW_SHUTDOWN_N, RD_VALID, CMD_ERROR, BUS_ACTIVE, TERM_A_CONNECT, TERM_W_CONNECT,
    TERM_B_CONNECT, SHUTDOWN_CFG, input wire [3:0] CMD_ADDR, input wire [1:0] CMD_OP,
    input wire [7:0] CMD_DATA, RD_DATA, WIPER_ACTIVE);
default clocking @(posedge CLK); endclocking
default disable iff (RST);
// Accepted command and terminal bundle
wire ok = CE && CMD_VALID && !CMD_ERROR;
wire [2:0] term = {TERM_A_CONNECT, TERM_W_CONNECT, TERM_B_CONNECT};
AST_IDLE: assert property ((CE && $stable(SDA_IN) && $stable(SCL_IN)) [*2] |=> !BUS_ACTIVE)
    else $error("bus active while lines static");
AST_RSV: assert property (CE && CMD_VALID && CMD_ADDR != 4'h0 && CMD_ADDR != 4'h4 |=> CMD_ERROR && !RD_VALID)
    else $error("reserved access not refused");
AST_TERMINAL_CONNECT_REG_OP: assert property (CE && CMD_VALID && CMD_ADDR == 4'h4 && (CMD_OP[1] ^ CMD_OP[0]) |=> CMD_ERROR)
    else $error("step on terminal control not refused");
AST_ERR_HOLD: assert property (CMD_ERROR && !START_SEEN |=> CMD_ERROR) else $error("error dropped");
AST_ERR_CLR: assert property (CE && CMD_ERROR && START_SEEN && !CMD_VALID |=> !CMD_ERROR)
    else $error("start did not clear error");
AST_RD_TERMINAL_CONNECT_REG: assert property (ok && CMD_OP == 2'h3 && CMD_ADDR == 4'h4 |=> RD_VALID && RD_DATA[7:4] == 4'hF)
    else $error("terminal control read wrong");
AST_HW_SHUTDOWN_N: assert property (!HW_SHUTDOWN_N [*2] |-> SHUTDOWN_CFG && term == 3'h3)
    else $error("hardware shutdown not applied");
AST_LATCH: assert property (CE && WRITE_LATCH_N |=> $stable(WIPER_ACTIVE)) else $error("wiper moved");
AST_TERMINAL_CONNECT_REG_LATE: assert property ((HW_SHUTDOWN_N && !CMD_DONE) [*3] |-> $stable(term))
    else $error("terminals changed before completion");
AST_RST: assert property ($fell(RST) |-> WIPER_ACTIVE == 8'h7F && term == 3'h7 && !SHUTDOWN_CFG)
    else $error("reset state wrong");
// Main scenarios reached
cover property (ok && CMD_OP == 2'h1);
cover property (HW_SHUTDOWN_N && SHUTDOWN_CFG);
cover property (CMD_ERROR ##1 !CMD_ERROR);
cover property ($fell(TERM_A_CONNECT));
endmodule // pot_register_map_properties
bind pot_register_map pot_register_map_properties u_pot_register_map_properties (.*);

// ===== tb/pot_host_model.sv
/* Serial host model issuing decoded register commands.
 Assumes tasks are entered in the time step of a rising CLK edge. */
`timescale 1ns/1ps
module pot_host_model (input wire CLK, output reg START_SEEN, CMD_VALID, CMD_DONE, SDA_IN, SCL_IN,
    output reg [3:0] CMD_ADDR, output reg [1:0] CMD_OP, output reg [7:0] CMD_DATA);
// Quiet lines until the first command
initial {START_SEEN, CMD_VALID, CMD_DONE, SDA_IN, SCL_IN, CMD_ADDR, CMD_OP, CMD_DATA} = 0;
// One command; released address and data show inverted values so stale data never matches
task cmd(input [3:0] a, input [1:0] o, input [7:0] d);
    begin
        CMD_VALID <= 1'h1; CMD_ADDR <= a; CMD_OP <= o; CMD_DATA <= d; SCL_IN <= ~SCL_IN;
        @(posedge CLK);
        CMD_VALID <= 1'h0; CMD_ADDR <= ~a; CMD_DATA <= ~d; SDA_IN <= ~SDA_IN;
    end
endtask
// Start (s high) clears a pending error; otherwise a completion pulse
task pulse(input s);
    begin
        if (s) START_SEEN <= 1'h1; else CMD_DONE <= 1'h1;
        @(posedge CLK);
        START_SEEN <= 1'h0; CMD_DONE <= 1'h0;
    end
endtask
endmodule // pot_host_model

// ===== tb/testbench.sv
/* Self-checking bench for the potentiometer register bank.
 Assumes the host model drives all command inputs; CE is tied high. */
`timescale 1ns/1ps
module testbench;
reg CLK = 0, RST = 1, WRITE_LATCH_N = 0, HW_SHUTDOWN_N = 1;
wire START_SEEN, CMD_VALID, CMD_DONE, SDA_IN, SCL_IN, RD_VALID, CMD_ERROR, BUS_ACTIVE, SHUTDOWN_CFG;
wire TERM_A_CONNECT, TERM_W_CONNECT, TERM_B_CONNECT;
wire [7:0] RD_DATA, WIPER_ACTIVE, CMD_DATA;
wire [3:0] CMD_ADDR;
wire [1:0] CMD_OP;
wire CE = 1'h1;
wire [7:0] term = {5'h0, TERM_A_CONNECT, TERM_W_CONNECT, TERM_B_CONNECT};
int bad_count = 0, checked = 0, cyc = 0, i;
always #50 CLK = ~CLK;
pot_register_map u_pot_register_map (.*);
pot_host_model u_pot_host_model (.*);
// Compare, issue, wait and verdict helpers
task chk(input string n, input [7:0] e, g);
    begin
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    end
endtask
task go(input [3:0] a, input [1:0] o, input [7:0] d);
    begin @(posedge CLK); u_pot_host_model.cmd(a, o, d); #1; end
endtask
task idle(input int n); begin repeat (n) @(posedge CLK); #1; end endtask
task st; begin @(posedge CLK); u_pot_host_model.pulse(1'h1); #1; end endtask
task report_and_stop;
    begin
        if (bad_count == 0 && checked > 0) $display("== PASSED =="); else $display("== FAILED ==");
        $finish;
    end
endtask
// Hang guard; the whole sequence needs well under a thousand cycles
always @(posedge CLK) begin
    cyc++;
    if (cyc > 3000) begin bad_count++; report_and_stop; end
end
initial begin
    repeat (2) @(posedge CLK); RST <= 1'h0; #1;
    chk("wiper", 8'h7F, WIPER_ACTIVE); chk("term", 8'h07, term);
    go(4'h0, 2'h3, 8'h00); chk("rd", 8'h7F, RD_DATA); chk("rdv", 8'h01, RD_VALID);
    go(4'h0, 2'h0, 8'hFF); go(4'h0, 2'h1, 8'h00); go(4'h0, 2'h3, 8'h00); chk("inc", 8'hFF, RD_DATA);
    go(4'h0, 2'h0, 8'h00); go(4'h0, 2'h2, 8'h00); go(4'h0, 2'h3, 8'h00); chk("dec", 8'h00, RD_DATA);
    go(4'h0, 2'h0, 8'h5A); idle(2); chk("wiper", 8'h5A, WIPER_ACTIVE);
    @(posedge CLK) WRITE_LATCH_N <= 1'h1;
    go(4'h0, 2'h0, 8'h33); idle(3); chk("held", 8'h5A, WIPER_ACTIVE);
    @(posedge CLK) WRITE_LATCH_N <= 1'h0;
    idle(2); chk("wiper", 8'h33, WIPER_ACTIVE);
    go(4'h4, 2'h0, 8'h0C); idle(2); chk("term", 8'h07, term);
    @(posedge CLK) u_pot_host_model.pulse(1'h0);
    idle(1); chk("term", 8'h04, term);
    go(4'h4, 2'h3, 8'h00); chk("terminal_connect_reg", 8'hFC, RD_DATA);
    @(posedge CLK) HW_SHUTDOWN_N <= 1'h0;
    idle(2); chk("hw_shutdown_n", 8'h0B, {SHUTDOWN_CFG, term[2:0]});
    @(posedge CLK) HW_SHUTDOWN_N <= 1'h1;
    idle(2); chk("term", 8'h04, term);
    go(4'h4, 2'h0, 8'h07); @(posedge CLK) u_pot_host_model.pulse(1'h0);
    idle(1); chk("soft", 8'h0B, {SHUTDOWN_CFG, term[2:0]});
    go(4'h4, 2'h3, 8'h00); chk("terminal_connect_reg", 8'hF7, RD_DATA);
    go(4'h4, 2'h0, 8'h0C); @(posedge CLK) u_pot_host_model.pulse(1'h0);
    idle(1); chk("term", 8'h04, term);
    go(4'h4, 2'h1, 8'h00); chk("err", 8'h01, CMD_ERROR);
    go(4'h0, 2'h3, 8'h00); chk("rdv", 8'h00, RD_VALID);
    st; chk("err", 8'h00, CMD_ERROR);
    go(4'h4, 2'h2, 8'h00); chk("err", 8'h01, CMD_ERROR); st;
    for (i = 1; i < 16; i++) if (i != 4) begin
        go(i[3:0], 2'h0, 8'h55); chk("rsv", 8'h01, CMD_ERROR); st;
    end
    go(4'h0, 2'h3, 8'h00); chk("rd", 8'h33, RD_DATA);
    go(4'h4, 2'h3, 8'h00); chk("terminal_connect_reg", 8'hFC, RD_DATA);
    idle(3); chk("act", 8'h00, BUS_ACTIVE);
    report_and_stop;
end
endmodule // testbench
